// ---- shared/pcrb_pkg.sv ----
package pcrb_pkg;
   // Feature-enable register field positions
   localparam int FE_PVI_BIT   = 1;
   localparam int FE_TSL_BIT   = 2;
   localparam int FE_DBX_BIT   = 3;
   localparam int FE_LPG_BIT   = 4;
   localparam int FE_WPA_BIT   = 5;
   localparam int FE_MCE_BIT   = 6;
   localparam int FE_GPG_BIT   = 7;
   localparam int FE_CRE_BIT   = 8;
   localparam int FE_FSS_BIT   = 9;
   localparam int FE_VXS_BIT   = 10;
   localparam int FE_VME_BIT   = 13;
   localparam int FE_SME_BIT   = 14;
   localparam int FE_SBA_BIT   = 16;
   localparam int FE_PCI_BIT   = 17;
   localparam int FE_XSE_BIT   = 18;
   localparam int FE_SEP_BIT   = 20;
   // Implemented feature-enable bits
   localparam logic [31:0] FE_IMPL_MASK = 32'h0017_67FE;
   localparam logic [31:0] FE_RESET     = 32'h0000_0000;
   // Priority threshold field
   localparam int          PT_WIDTH     = 4;
   localparam logic [3:0]  PT_ALL_OFF   = 4'hF;
   localparam logic [63:0] PT_RESET     = 64'h0000_0000_0000_0000;
   // Extended state-enable register
   localparam int          XS_BASE_BIT  = 0;
   localparam int          XS_VEC_BIT   = 1;
   localparam int          XS_WIDE_BIT  = 2;
   localparam int          XS_RSVD_BIT  = 63;
   localparam logic [63:0] XS_RESET     = 64'h0000_0000_0000_0001;
   localparam logic [63:0] XS_SUPPORTED = 64'h0000_0000_0000_0007;
   // Identification mirror bit position
   localparam int          ID_XSE_BIT   = 27;
   // Register select codes
   typedef enum logic [1:0]
   {
      PCRB_SEL_FE = 2'b00,
      PCRB_SEL_PT = 2'b01,
      PCRB_SEL_XS = 2'b10,
      PCRB_SEL_NO = 2'b11
   } pcrb_sel_t;
endpackage

// ---- shared/pcrb_chk_if.sv ----
`timescale 1ns/1ns
// Write-check carrier between bank and checker
interface pcrb_chk_if;
   import pcrb_pkg::*;
   logic [63:0] wdata;
   logic [63:0] supported;
   logic        fault;
   modport bank (output wdata, output supported, input fault);
   modport chk  (input wdata, input supported, output fault);
endinterface

// ---- core/pcrb_xs_check.sv ----
`timescale 1ns/1ns
// Legality check for an extended state-enable write
module pcrb_xs_check
   import pcrb_pkg::*;
(
   pcrb_chk_if.chk c
);
   // Fault terms
   always_comb
   begin
      c.fault = 1'b0;
      if (!c.wdata[XS_BASE_BIT])
      begin
         c.fault = 1'b1;
      end
      if (!c.wdata[XS_VEC_BIT] && c.wdata[XS_WIDE_BIT])
      begin
         c.fault = 1'b1;
      end
      if ((c.wdata & ~c.supported) != 64'h0000_0000_0000_0000)
      begin
         c.fault = 1'b1;
      end
   end
endmodule

// ---- core/pcrb_bank.sv ----
`timescale 1ns/1ns
module pcrb_bank
   import pcrb_pkg::*;
#(
   parameter logic [63:0] XS_SUPPORT = XS_SUPPORTED
)
(
   // Clock and reset
   input  wire logic        SYS_CLK_I,
   input  wire logic        RESET_I,
   // Register access request
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   input  wire logic [1:0]  SEL_I,
   input  wire logic [63:0] WDATA_I,
   input  wire logic [1:0]  CPL_I,
   input  wire logic        LONG_MODE_ACTIVE_I,
   // Instruction and event qualification
   input  wire logic        TIME_STAMP_READ_I,
   input  wire logic        PERF_COUNTER_READ_I,
   input  wire logic        DEBUG_REG_REF_I,
   input  wire logic        VECTOR_INSN_I,
   input  wire logic        VECTOR_EXEMPT_I,
   input  wire logic        SEGMENT_BASE_INSN_I,
   input  wire logic        VECTOR_FP_EXC_I,
   input  wire logic        MACHINE_CHECK_I,
   input  wire logic [3:0]  IRQ_PRIORITY_I,
   // Read answer
   output logic [63:0]      RDATA_O,
   output logic             RVALID_O,
   // Faults
   output logic             GENERAL_PROTECTION_FAULT_O,
   output logic             UNDEFINED_OPCODE_FAULT_O,
   output logic             VECTOR_FP_FAULT_O,
   output logic             MACHINE_CHECK_O,
   output logic             DEBUG_REG_ALIAS_O,
   output logic             IRQ_ALLOWED_O,
   // Feature controls to consumers
   output logic             VIRTUAL_INTERRUPT_FLAG_EN_O,
   output logic             LARGE_PAGE_ENABLE_O,
   output logic             WIDE_PHYSICAL_ADDRESS_O,
   output logic             GLOBAL_PAGE_ENABLE_O,
   output logic             VECTOR_STATE_SAVE_O,
   output logic             VIRTUAL_MACHINE_ENABLE_O,
   output logic             SAFER_MODE_ENABLE_O,
   output logic             PROCESS_CONTEXT_ID_ENABLE_O,
   output logic             SUPERVISOR_EXEC_PREVENT_O,
   output logic             ID_EXTENDED_SAVE_O,
   output logic [63:0]      EXT_STATE_ENABLE_O
);

   // Complete module state
   typedef struct packed
   {
      logic [31:0] fe;
      logic [63:0] pt;
      logic [63:0] xs;
      logic [63:0] rdata;
      logic        rvalid;
      logic        gp;
      logic        ud;
      logic        xf;
      logic        mc;
      logic        dbg_alias;
      logic        irq_ok;
      logic [9:0]  ctl;
   } pcrb_state_t;

   pcrb_state_t st_ff;
   pcrb_state_t nxt_st;

   pcrb_chk_if  chk ();
   pcrb_sel_t   sel;
   logic        sel_fe;
   logic        sel_pt;
   logic        sel_xs;
   logic        sel_no;
   logic        priv;
   logic        xs_open;
   logic        wr_fault;
   logic [31:0] fe_new;

   // One-hot register select, shared by the fault, write and read paths
   function automatic logic [3:0] sel_decode(input pcrb_sel_t s);
      logic [3:0] hot;
      hot = 4'h0;
      if (s == PCRB_SEL_FE)
      begin
         hot[0] = 1'b1;
      end
      else if (s == PCRB_SEL_PT)
      begin
         hot[1] = 1'b1;
      end
      else if (s == PCRB_SEL_XS)
      begin
         hot[2] = 1'b1;
      end
      else
      begin
         hot[3] = 1'b1;
      end
      return hot;
   endfunction

   // Request qualifiers
   assign sel           = pcrb_sel_t'(SEL_I);
   assign {sel_no, sel_xs, sel_pt, sel_fe} = sel_decode(sel);
   assign priv          = (CPL_I == 2'h0);
   assign xs_open       = st_ff.fe[FE_XSE_BIT];
   // Bit 63 never names a state component, whatever the parameter holds
   assign chk.wdata     = WDATA_I;
   assign chk.supported = XS_SUPPORT & ~(64'h1 << XS_RSVD_BIT);

   // Extended write legality check
   pcrb_xs_check u_chk
   (
      .c (chk)
   );

   // Candidate feature-enable value
   // Unimplemented bits are dropped, so they always read back as zero
   assign fe_new = WDATA_I[31:0] & FE_IMPL_MASK;

   // Write fault decode; privilege is checked before any register rule
   always_comb
   begin
      wr_fault = 1'b0;
      if (!priv)
      begin
         wr_fault = 1'b1;
      end
      else if (sel_fe)
      begin
         // Context ids may only be switched on while long mode is active
         if (fe_new[FE_PCI_BIT] && !st_ff.fe[FE_PCI_BIT] && !LONG_MODE_ACTIVE_I)
         begin
            wr_fault = 1'b1;
         end
      end
      else if (sel_pt)
      begin
         wr_fault = 1'b0;                                   // Any threshold value accepted
      end
      else if (sel_xs)
      begin
         if (!xs_open)
         begin
            wr_fault = 1'b1;
         end
         else if (chk.fault)
         begin
            wr_fault = 1'b1;
         end
      end
      else
      begin
         wr_fault = 1'b1;
      end
   end

   // Next-state computation
   always_comb
   begin
      nxt_st        = st_ff;
      nxt_st.rvalid = 1'b0;
      nxt_st.gp     = 1'b0;
      // Register writes; faulting writes keep contents
      if (WR_I)
      begin
         nxt_st.gp = wr_fault;
         if (!wr_fault)
         begin
            if (sel_fe)
            begin
               nxt_st.fe = fe_new;
            end
            else if (sel_pt)
            begin
               nxt_st.pt = {60'h0, WDATA_I[PT_WIDTH-1:0]};
            end
            else if (sel_xs)
            begin
               nxt_st.xs = WDATA_I;
            end
         end
      end
      // Register reads
      else if (RD_I)
      begin
         // Extended register answers at any privilege once opened
         if (sel_xs && !xs_open)
         begin
            nxt_st.gp = 1'b1;
         end
         else if (sel_xs)
         begin
            nxt_st.rdata  = st_ff.xs;
            nxt_st.rvalid = 1'b1;
         end
         // Control registers are privileged; the unmapped code never answers
         else if (!priv || sel_no)
         begin
            nxt_st.gp = 1'b1;
         end
         else if (sel_fe)
         begin
            nxt_st.rdata  = {32'h0, st_ff.fe};
            nxt_st.rvalid = 1'b1;
         end
         else
         begin
            nxt_st.rdata  = st_ff.pt;
            nxt_st.rvalid = 1'b1;
         end
      end
      // Instruction gating faults
      nxt_st.ud = 1'b0;

      // Time-stamp reads outside level 0 while locked
      if (TIME_STAMP_READ_I && st_ff.fe[FE_TSL_BIT] && !priv)
      begin
         nxt_st.gp = 1'b1;
      end

      // Counter reads outside level 0 unless opened to all levels
      if (PERF_COUNTER_READ_I && !st_ff.fe[FE_CRE_BIT] && !priv)
      begin
         nxt_st.gp = 1'b1;
      end

      // Debug register four/five references fault under the extension
      if (DEBUG_REG_REF_I && st_ff.fe[FE_DBX_BIT])
      begin
         nxt_st.ud = 1'b1;
      end

      // Vector instructions need fast-save support, exempt ones excepted
      if (VECTOR_INSN_I && !VECTOR_EXEMPT_I && !st_ff.fe[FE_FSS_BIT])
      begin
         nxt_st.ud = 1'b1;
      end

      // Segment-base instructions need their own enable
      if (SEGMENT_BASE_INSN_I && !st_ff.fe[FE_SBA_BIT])
      begin
         nxt_st.ud = 1'b1;
      end

      // Unsupported vector exceptions become undefined-opcode faults
      if (VECTOR_FP_EXC_I && !st_ff.fe[FE_VXS_BIT])
      begin
         nxt_st.ud = 1'b1;
      end
      nxt_st.xf        = VECTOR_FP_EXC_I && st_ff.fe[FE_VXS_BIT];
      nxt_st.dbg_alias = DEBUG_REG_REF_I && !st_ff.fe[FE_DBX_BIT];
      nxt_st.mc        = MACHINE_CHECK_I && st_ff.fe[FE_MCE_BIT];
      // Priority threshold compare
      // Class 0 never passes, and threshold 15 holds back every class
      nxt_st.irq_ok    = (st_ff.pt[3:0] != PT_ALL_OFF) &&
                         (IRQ_PRIORITY_I > st_ff.pt[3:0]);
      // Registered feature outputs
      nxt_st.ctl[0]  = st_ff.fe[FE_PVI_BIT];
      nxt_st.ctl[1]  = st_ff.fe[FE_LPG_BIT];
      nxt_st.ctl[2]  = st_ff.fe[FE_WPA_BIT];
      nxt_st.ctl[3]  = st_ff.fe[FE_GPG_BIT];
      nxt_st.ctl[4]  = st_ff.fe[FE_FSS_BIT];
      nxt_st.ctl[5]  = st_ff.fe[FE_VME_BIT];
      nxt_st.ctl[6]  = st_ff.fe[FE_SME_BIT];
      nxt_st.ctl[7]  = st_ff.fe[FE_PCI_BIT];
      nxt_st.ctl[8]  = st_ff.fe[FE_SEP_BIT];
      nxt_st.ctl[9]  = st_ff.fe[FE_XSE_BIT];
   end

   // State register
   always_ff @(posedge SYS_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         // Every field to a constant; only the extended register is non-zero
         st_ff.fe        <= FE_RESET;
         st_ff.pt        <= PT_RESET;
         st_ff.xs        <= XS_RESET;
         st_ff.rdata     <= 64'h0000_0000_0000_0000;
         st_ff.rvalid    <= 1'b0;
         st_ff.gp        <= 1'b0;
         st_ff.ud        <= 1'b0;
         st_ff.xf        <= 1'b0;
         st_ff.mc        <= 1'b0;
         st_ff.dbg_alias <= 1'b0;
         st_ff.irq_ok    <= 1'b0;
         st_ff.ctl       <= 10'h000;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // Read answer and fault pulses, straight from state flops
   assign RDATA_O                     = st_ff.rdata;
   assign RVALID_O                    = st_ff.rvalid;
   assign GENERAL_PROTECTION_FAULT_O  = st_ff.gp;
   assign UNDEFINED_OPCODE_FAULT_O    = st_ff.ud;
   assign VECTOR_FP_FAULT_O           = st_ff.xf;
   assign MACHINE_CHECK_O             = st_ff.mc;
   assign DEBUG_REG_ALIAS_O           = st_ff.dbg_alias;
   assign IRQ_ALLOWED_O               = st_ff.irq_ok;

   // Feature levels, one cycle behind the register
   assign VIRTUAL_INTERRUPT_FLAG_EN_O = st_ff.ctl[0];
   assign LARGE_PAGE_ENABLE_O         = st_ff.ctl[1];
   assign WIDE_PHYSICAL_ADDRESS_O     = st_ff.ctl[2];
   assign GLOBAL_PAGE_ENABLE_O        = st_ff.ctl[3];
   assign VECTOR_STATE_SAVE_O         = st_ff.ctl[4];
   assign VIRTUAL_MACHINE_ENABLE_O    = st_ff.ctl[5];
   assign SAFER_MODE_ENABLE_O         = st_ff.ctl[6];
   assign PROCESS_CONTEXT_ID_ENABLE_O = st_ff.ctl[7];
   assign SUPERVISOR_EXEC_PREVENT_O   = st_ff.ctl[8];
   assign ID_EXTENDED_SAVE_O          = st_ff.ctl[9];

   // Extended register, no lag after the write edge
   assign EXT_STATE_ENABLE_O          = st_ff.xs;
endmodule

// ---- tb/pcrb_bank_monitor.sv ----
`timescale 1ns/1ns
// Port-level checks of the register bank
module pcrb_bank_monitor
   import pcrb_pkg::*;
(
   input wire logic        SYS_CLK_I,
   input wire logic        RESET_I,
   input wire logic        WR_I,
   input wire logic        RD_I,
   input wire logic [1:0]  SEL_I,
   input wire logic [1:0]  CPL_I,
   input wire logic        LONG_MODE_ACTIVE_I,
   input wire logic        DEBUG_REG_REF_I,
   input wire logic        VECTOR_INSN_I,
   input wire logic        VECTOR_EXEMPT_I,
   input wire logic        SEGMENT_BASE_INSN_I,
   input wire logic        VECTOR_FP_EXC_I,
   input wire logic [3:0]  IRQ_PRIORITY_I,
   input wire logic        RVALID_O,
   input wire logic        GENERAL_PROTECTION_FAULT_O,
   input wire logic        UNDEFINED_OPCODE_FAULT_O,
   input wire logic        VECTOR_FP_FAULT_O,
   input wire logic        DEBUG_REG_ALIAS_O,
   input wire logic        IRQ_ALLOWED_O,
   input wire logic        PROCESS_CONTEXT_ID_ENABLE_O,
   input wire logic [63:0] EXT_STATE_ENABLE_O
);
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (RESET_I);
   // Write and read answers
   property p_gp_cpl;
      WR_I && CPL_I != 2'h0 |=> GENERAL_PROTECTION_FAULT_O;
   endproperty
   a_gp_cpl: assert property (p_gp_cpl) else $error("unprivileged write accepted");
   property p_xs_fix;
      EXT_STATE_ENABLE_O[0] && !EXT_STATE_ENABLE_O[63];
   endproperty
   a_xs_fix: assert property (p_xs_fix) else $error("fixed extended bit wrong");
   property p_keep;
      WR_I && SEL_I == PCRB_SEL_XS ##1 GENERAL_PROTECTION_FAULT_O |-> $stable(EXT_STATE_ENABLE_O);
   endproperty
   a_keep: assert property (p_keep) else $error("faulting write changed register");
   property p_rd;
      RD_I && !WR_I |=> RVALID_O || GENERAL_PROTECTION_FAULT_O;
   endproperty
   a_rd: assert property (p_rd) else $error("read got no answer");
   // Event qualification
   property p_dbg;
      DEBUG_REG_REF_I && !VECTOR_INSN_I && !SEGMENT_BASE_INSN_I && !VECTOR_FP_EXC_I
         |=> UNDEFINED_OPCODE_FAULT_O != DEBUG_REG_ALIAS_O;
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug reference not fault or alias");
   property p_vfp;
      VECTOR_FP_EXC_I |=> VECTOR_FP_FAULT_O || UNDEFINED_OPCODE_FAULT_O;
   endproperty
   a_vfp: assert property (p_vfp) else $error("vector exception not reported");
   property p_exempt;
      VECTOR_INSN_I && VECTOR_EXEMPT_I && !DEBUG_REG_REF_I && !SEGMENT_BASE_INSN_I && !VECTOR_FP_EXC_I
         |=> !UNDEFINED_OPCODE_FAULT_O;
   endproperty
   a_exempt: assert property (p_exempt) else $error("exempt instruction faulted");
   property p_irq;
      IRQ_ALLOWED_O |-> $past(IRQ_PRIORITY_I) != 4'h0;
   endproperty
   a_irq: assert property (p_irq) else $error("priority zero let through");
   property p_pcid;
      $rose(PROCESS_CONTEXT_ID_ENABLE_O) |-> $past(LONG_MODE_ACTIVE_I, 2);
   endproperty
   a_pcid: assert property (p_pcid) else $error("context ids set outside long mode");
endmodule

// ---- tb/pcrb_bank_tb.sv ----
`timescale 1ns/1ns
// Directed register and event tests
module pcrb_bank_tb
   import pcrb_pkg::*;
;
   logic        clk, rst, wr, rd, lma, gpf, udf, vff, mco, als, irq, rv;
   logic [1:0]  sel, cpl;
   logic [3:0]  prio;
   logic [7:0]  evs;
   logic [9:0]  feat;
   logic [63:0] wdata, rdata, ext;
   int          fails, n_checks;
   logic [63:0] xv [4] = '{64'h6, 64'h5, 64'h9, 64'h8000_0000_0000_0001};
   logic [7:0]  evc [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h18, 8'h20, 8'h40, 8'h80};
   logic [4:0]  e_on [8] = '{5'h10, 5'h0, 5'h8, 5'h0, 5'h0, 5'h0, 5'h4, 5'h2};
   logic [4:0]  e_off [8] = '{5'h0, 5'h10, 5'h1, 5'h8, 5'h0, 5'h8, 5'h8, 5'h0};
   pcrb_bank dut_u (.SYS_CLK_I(clk), .RESET_I(rst), .WR_I(wr), .RD_I(rd), .SEL_I(sel), .WDATA_I(wdata),
      .CPL_I(cpl), .LONG_MODE_ACTIVE_I(lma), .TIME_STAMP_READ_I(evs[0]), .PERF_COUNTER_READ_I(evs[1]),
      .DEBUG_REG_REF_I(evs[2]), .VECTOR_INSN_I(evs[3]), .VECTOR_EXEMPT_I(evs[4]), .SEGMENT_BASE_INSN_I(evs[5]),
      .VECTOR_FP_EXC_I(evs[6]), .MACHINE_CHECK_I(evs[7]), .IRQ_PRIORITY_I(prio), .RDATA_O(rdata),
      .RVALID_O(rv), .GENERAL_PROTECTION_FAULT_O(gpf), .UNDEFINED_OPCODE_FAULT_O(udf),
      .VECTOR_FP_FAULT_O(vff), .MACHINE_CHECK_O(mco), .DEBUG_REG_ALIAS_O(als), .IRQ_ALLOWED_O(irq),
      .VIRTUAL_INTERRUPT_FLAG_EN_O(feat[9]), .LARGE_PAGE_ENABLE_O(feat[8]), .WIDE_PHYSICAL_ADDRESS_O(feat[7]),
      .GLOBAL_PAGE_ENABLE_O(feat[6]), .VECTOR_STATE_SAVE_O(feat[5]), .VIRTUAL_MACHINE_ENABLE_O(feat[4]),
      .SAFER_MODE_ENABLE_O(feat[3]), .PROCESS_CONTEXT_ID_ENABLE_O(feat[2]),
      .SUPERVISOR_EXEC_PREVENT_O(feat[1]), .ID_EXTENDED_SAVE_O(feat[0]), .EXT_STATE_ENABLE_O(ext));
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic cmp(input string nm, input logic [63:0] exp, input logic [63:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One register access, answer sampled in the following cycle
   task automatic acc(input logic w, input logic [1:0] s, input logic [63:0] d, input logic [1:0] c,
                      input logic g, input logic [63:0] x);
      @(negedge clk);
      wr = w;
      rd = !w;
      sel = s;
      wdata = d;
      cpl = c;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
      cmp("fault", 64'(g), 64'(gpf));
      cmp("rvalid", 64'(!w && !g), 64'(rv));
      if (!w && !g)
         cmp("rdata", x, rdata);
   endtask
   task automatic ev(input logic [7:0] e, input logic [4:0] x);
      @(negedge clk);
      evs = e;
      cpl = 2'h3;
      @(negedge clk);
      evs = 8'h0;
      cmp("event", 64'(x), 64'({gpf, udf, vff, mco, als}));
   endtask
   task automatic irq_t(input logic [3:0] p, input logic x);
      @(negedge clk);
      prio = p;
      @(negedge clk);
      cmp("irq", 64'(x), 64'(irq));
   endtask
   task automatic conclude();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #100000;
      fails++;
      conclude();
   end
   // Main sequence
   initial
   begin
      {wr, rd, lma, sel, cpl, prio, evs, wdata} = '0;
      rst = 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      cmp("ext", 64'h1, ext);
      acc(0, 2, 0, 0, 1, 0);
      acc(0, 0, 0, 0, 0, 64'h0);
      acc(0, 3, 0, 0, 1, 0);
      acc(1, 0, 64'hFFFF_FFFF, 3, 1, 0);
      acc(1, 0, 64'hFFFF_FFFF, 0, 1, 0);
      acc(0, 0, 0, 0, 0, 64'h0);
      lma = 1'b1;
      acc(1, 0, 64'hFFFF_FFFF, 0, 0, 0);
      acc(0, 0, 0, 0, 0, 64'h0017_67FE);
      @(negedge clk);
      cmp("features", 64'h3FF, 64'(feat));
      acc(1, 2, 64'h7, 0, 0, 0);
      foreach (xv[i])
      begin
         acc(1, 2, xv[i], 0, 1, 0);
         cmp("ext", 64'h7, ext);
      end
      acc(0, 2, 0, 3, 0, 64'h7);
      acc(1, 1, 64'hFF, 0, 0, 0);
      acc(0, 1, 0, 0, 0, 64'hF);
      irq_t(4'hF, 1'b0);
      acc(1, 1, 64'h5, 0, 0, 0);
      irq_t(4'h5, 1'b0);
      irq_t(4'h6, 1'b1);
      acc(1, 1, 64'h0, 0, 0, 0);
      irq_t(4'h1, 1'b1);
      irq_t(4'h0, 1'b0);
      foreach (evc[i])
         ev(evc[i], e_on[i]);
      acc(1, 0, 64'h0, 0, 0, 0);
      foreach (evc[i])
         ev(evc[i], e_off[i]);
      acc(0, 2, 0, 0, 1, 0);
      acc(1, 1, 64'h9, 0, 0, 0);
      // Reset in mid-run
      @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      cmp("ext", 64'h1, ext);
      acc(0, 1, 0, 0, 0, 64'h0);
      acc(0, 0, 0, 0, 0, 64'h0);
      cmp("features", 64'h0, 64'(feat));
      acc(1, 0, 64'h0002_2222, 0, 0, 0);
      @(negedge clk);
      cmp("features", 64'h2B4, 64'(feat));
      conclude();
   end
endmodule
bind pcrb_bank pcrb_bank_monitor mon_u (.SYS_CLK_I, .RESET_I, .WR_I, .RD_I, .SEL_I, .CPL_I, .LONG_MODE_ACTIVE_I,
   .DEBUG_REG_REF_I, .VECTOR_INSN_I, .VECTOR_EXEMPT_I, .SEGMENT_BASE_INSN_I, .VECTOR_FP_EXC_I, .IRQ_PRIORITY_I,
   .RVALID_O, .GENERAL_PROTECTION_FAULT_O, .UNDEFINED_OPCODE_FAULT_O, .VECTOR_FP_FAULT_O, .DEBUG_REG_ALIAS_O,
   .IRQ_ALLOWED_O, .PROCESS_CONTEXT_ID_ENABLE_O, .EXT_STATE_ENABLE_O);
